// ---- design/bridge_ctl_pkg.sv ----
// shared constants and types for the data path and reset controller
`default_nettype none
package bridge_ctl_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int IDLE_TIME_NS = 1000;
   localparam int IDLE_CYCLES = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ALIGN_CYCLES = 16;
   localparam int SYNC_W = 12;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_DECODE = 8'h08;

   localparam int CTRL_GO = 0;
   localparam int CTRL_DMA = 1;
   localparam int CTRL_CODE_LO = 2;
   localparam int CTRL_WORDS_LO = 8;
   localparam int CTRL_RST_OUT = 12;
   localparam int CTRL_IFACE_RST = 13;
   localparam int CTRL_SYS_RST = 14;

   localparam int STAT_DONE = 0;
   localparam int STAT_PREEMPT = 1;
   localparam int STAT_BUSY = 2;
   localparam int STAT_UNALIGNED = 3;
   localparam int STAT_IDLE = 4;
   localparam int STAT_ALIGNED = 5;
   localparam int STAT_SLAVE_HIT = 6;
   localparam int STAT_FSM_LO = 8;

   localparam logic [2:0] ACT_RESERVED = 3'h0;
   localparam logic [1:0] RQ_NONE = 2'h0;
   localparam logic [1:0] RQ_DMA = 2'h1;
   localparam logic [1:0] RQ_OTHER = 2'h2;

   localparam logic [3:0] SDEC_NONE = 4'h0;
   localparam logic [3:0] SDEC_MEM = 4'h1;
   localparam logic [3:0] SDEC_EXT = 4'h2;
   localparam logic [3:0] SDEC_HCSR = 4'h3;
   localparam logic [3:0] SDEC_MBOX = 4'h4;
   localparam logic [3:0] SDEC_SPLIT = 4'h6;
   localparam logic [3:0] SDEC_BPCSR = 4'h7;
   localparam logic [3:0] SDEC_BCSR = 4'h9;
   localparam logic [3:0] SDEC_DPUCSR = 4'hD;
   localparam logic [3:0] MDEC_LAST = 4'h6;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_REQ = 7'h02,
      ST_LOAD = 7'h04,
      ST_STROBE = 7'h08,
      ST_XFER = 7'h10,
      ST_STEP = 7'h20,
      ST_END = 7'h40
   } fsm_t;

   typedef struct packed {
      logic addr_load_n;
      logic owner_n;
      logic [2:0] action;
      logic strobe_n;
      logic step_n;
      logic selected_n;
   } dpu_ctl_t;

   typedef struct packed {
      logic [3:0] addr_decode;
      logic unaligned_n;
      logic arb_a;
      logic arb_b;
      logic tenure_end;
      logic awarded;
      logic takeover;
      logic pwr_rst_n;
      logic align_skip_n;
   } pins_in_t;

   localparam dpu_ctl_t DPU_IDLE = '{addr_load_n: 1'b1, owner_n: 1'b1, action: 3'h0,
                                     strobe_n: 1'b1, step_n: 1'b1, selected_n: 1'b1};
endpackage : bridge_ctl_pkg
`default_nettype wire

// ---- design/pin_sync.sv ----
// two flip-flop synchroniser for the pin inputs
`default_nettype none
module pin_sync import bridge_ctl_pkg::*; (
   input wire logic CLK,
   input wire logic CE,
   input wire logic [SYNC_W-1:0] d,
   output logic [SYNC_W-1:0] q
);
   logic [SYNC_W-1:0] meta_reg;
   logic [SYNC_W-1:0] out_reg;
   genvar i;
   generate
      for (i = 0; i < SYNC_W; i++) begin : g_bit
         always_ff @(posedge CLK) begin
            if (CE) begin
               meta_reg[i] <= d[i];
               out_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
   assign q = out_reg;
endmodule : pin_sync
`default_nettype wire

// ---- design/idle_timer.sv ----
// measures how long the arbitration handshake has stayed quiet
`default_nettype none
module idle_timer import bridge_ctl_pkg::*; (
   input wire logic CLK,
   input wire logic CE,
   input wire logic clear,
   input wire logic quiet,
   output logic idle
);
   typedef struct packed {
      logic [6:0] count;
      logic idle;
   } tmr_t;
   localparam logic [6:0] LIMIT = 7'(IDLE_CYCLES);
   tmr_t s_reg;
   tmr_t s_next;

   always_comb begin
      s_next = s_reg;
      if (clear || !quiet) begin
         s_next = '0;
      end else if (s_reg.count <= LIMIT) begin
         s_next.count = s_reg.count + 7'h01;
      end
      // idle only once strictly more than the quiet time has passed
      s_next.idle = quiet && !clear && (s_reg.count > LIMIT);
   end

   always_ff @(posedge CLK) begin
      if (clear) begin
         s_reg <= '0;
      end else if (CE) begin
         s_reg <= s_next;
      end
   end
   assign idle = s_reg.idle;
endmodule : idle_timer
`default_nettype wire

// ---- design/dp_reset_ctl.sv ----
// control side for the companion data path unit, tenure handling and reset port
// Function
// RULE1 - slave decode codes 1,2,3,4,6,7,9,13 select this module, others unselected
// RULE2 - master decode codes 1 to 6 are capabilities, higher codes reserved
// RULE3 - address load goes low once the requested backplane grant arrives
// RULE4 - host owner goes low while this device masters the host transaction
// RULE5 - a three bit action code tells the unit what to do, 000 reserved
// RULE6 - action strobe pulses low once to start the selected action
// RULE7 - address step pulses low once per transferred word
// RULE8 - module selected goes low when a backplane transaction targets us
// RULE9 - the unit drives unaligned low for partial unaligned slave transfers
// RULE10 - arbitration handshake pair low and high means arbitration bus quiet
// RULE11 - bus idle flag low only when idle over 1 us and reset out set
// RULE12 - open collector output requests a bus interface reset
// RULE13 - separate open collector output requests a full system reset
// RULE14 - power up reset pin clears all logic and releases every output
// RULE15 - alignment sequence after power up is skipped when bypass is low
// RULE16 - tenure starts only after grant and released end of tenure
// RULE17 - request level 0 for DMA, level 1 for everything else
// RULE18 - command transceiver direction high to read, low to write
// RULE19 - preemption ends the current mastership after the current word
`default_nettype none
module dp_reset_ctl import bridge_ctl_pkg::*; (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [3:0] HOST_ADDR_DECODE,
   input wire logic UNALIGNED_N,
   input wire logic ARB_QUIET_HS_A,
   input wire logic ARB_QUIET_HS_B,
   input wire logic TENURE_END_IN,
   input wire logic MASTERSHIP_AWARDED_IN,
   input wire logic TAKEOVER_IN,
   input wire logic PWR_RESET_N,
   input wire logic ALIGN_SKIP_N,
   output logic GRANT_ADDR_LOAD_N,
   output logic HOST_SIDE_OWNER_N,
   output logic [2:0] HOST_ACTION_CODE,
   output logic HOST_ACTION_STROBE_N,
   output logic ADDR_STEP_N,
   output logic MODULE_SELECTED_N,
   output logic [1:0] TENURE_REQUEST_LEVEL,
   output logic CMD_XCVR_DIR,
   output logic BACKPLANE_RESET_OUT,
   output logic IDLE_BUS_FLAG_N,
   output logic IFACE_RESET_REQUEST_N_O,
   output logic IFACE_RESET_REQUEST_N_OE,
   output logic WHOLE_SYSTEM_RESET_REQUEST_N_O,
   output logic WHOLE_SYSTEM_RESET_REQUEST_N_OE
);
   typedef struct packed {
      fsm_t fsm;
      dpu_ctl_t dpu;
      logic dma;
      logic [2:0] code;
      logic [3:0] words;
      logic [1:0] rq;
      logic dir;
      logic rst_out;
      logic iface_rst;
      logic sys_rst;
      logic idle_n;
      logic done;
      logic preempt;
      logic unaligned;
      logic slave_hit;
      logic [3:0] last_decode;
      logic [4:0] align_cnt;
      logic aligned;
      logic ack;
      logic [31:0] rdata;
   } st_t;

   localparam st_t ST_RESET = '{fsm: ST_IDLE, dpu: DPU_IDLE, dma: 1'b0, code: 3'h0, words: 4'h0,
                                rq: RQ_NONE, dir: 1'b1, rst_out: 1'b0, iface_rst: 1'b0, sys_rst: 1'b0,
                                idle_n: 1'b1, done: 1'b0, preempt: 1'b0, unaligned: 1'b0,
                                slave_hit: 1'b0, last_decode: 4'h0, align_cnt: 5'h00, aligned: 1'b0,
                                ack: 1'b0, rdata: 32'h0000_0000};
   localparam logic [4:0] ALIGN_LAST = 5'(ALIGN_CYCLES);

   st_t s_reg;
   st_t s_next;
   pins_in_t pin_s;
   logic bus_idle;
   logic arb_quiet;

   pin_sync u_sync (
      .CLK(CLK),
      .CE(CE),
      .d({HOST_ADDR_DECODE, UNALIGNED_N, ARB_QUIET_HS_A, ARB_QUIET_HS_B, TENURE_END_IN,
          MASTERSHIP_AWARDED_IN, TAKEOVER_IN, PWR_RESET_N, ALIGN_SKIP_N}),
      .q(pin_s)
   );

   assign arb_quiet = !pin_s.arb_a && pin_s.arb_b; // RULE10

   idle_timer u_idle (
      .CLK(CLK),
      .CE(CE),
      .clear(RESET || !pin_s.pwr_rst_n),
      .quiet(arb_quiet),
      .idle(bus_idle)
   );

   function automatic logic slave_hit(input logic [3:0] dec);
      case (dec)
         SDEC_MEM, SDEC_EXT, SDEC_HCSR, SDEC_MBOX, SDEC_SPLIT, SDEC_BPCSR, SDEC_BCSR, SDEC_DPUCSR: slave_hit = 1'b1;
         default: slave_hit = 1'b0;
      endcase
   endfunction : slave_hit

   function automatic logic master_cap(input logic [3:0] dec); // RULE2
      master_cap = (dec != SDEC_NONE) && (dec <= MDEC_LAST);
   endfunction : master_cap

   logic wb_req;
   logic wr_ctrl;
   logic wr_stat;
   logic go;
   logic [31:0] ctrl_view;
   logic [31:0] stat_view;

   always_comb begin
      wb_req = WB_CYC_I && WB_STB_I && !s_reg.ack;
      wr_ctrl = wb_req && WB_WE_I && (WB_ADR_I == OFS_CTRL);
      wr_stat = wb_req && WB_WE_I && (WB_ADR_I == OFS_STATUS) && WB_SEL_I[0];
      go = wr_ctrl && WB_SEL_I[0] && WB_DAT_I[CTRL_GO];
      ctrl_view = '0;
      ctrl_view[CTRL_DMA] = s_reg.dma;
      ctrl_view[CTRL_CODE_LO +: 3] = s_reg.code;
      ctrl_view[CTRL_WORDS_LO +: 4] = s_reg.words;
      ctrl_view[CTRL_RST_OUT] = s_reg.rst_out;
      ctrl_view[CTRL_IFACE_RST] = s_reg.iface_rst;
      ctrl_view[CTRL_SYS_RST] = s_reg.sys_rst;
      stat_view = '0;
      stat_view[STAT_DONE] = s_reg.done;
      stat_view[STAT_PREEMPT] = s_reg.preempt;
      stat_view[STAT_BUSY] = (s_reg.fsm != ST_IDLE);
      stat_view[STAT_UNALIGNED] = s_reg.unaligned;
      stat_view[STAT_IDLE] = bus_idle;
      stat_view[STAT_ALIGNED] = s_reg.aligned;
      stat_view[STAT_SLAVE_HIT] = s_reg.slave_hit;
      stat_view[STAT_FSM_LO +: 7] = s_reg.fsm;

      s_next = s_reg;
      s_next.ack = wb_req;
      if (wb_req && !WB_WE_I) begin
         case (WB_ADR_I)
            OFS_CTRL: s_next.rdata = ctrl_view;
            OFS_STATUS: s_next.rdata = stat_view;
            OFS_DECODE: s_next.rdata = {27'h0000000, master_cap(s_reg.last_decode), s_reg.last_decode};
            default: s_next.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_ctrl && WB_SEL_I[0] && (s_reg.fsm == ST_IDLE)) begin
         s_next.dma = WB_DAT_I[CTRL_DMA];
         s_next.code = WB_DAT_I[CTRL_CODE_LO +: 3];
      end
      if (wr_ctrl && WB_SEL_I[1]) begin
         if (s_reg.fsm == ST_IDLE) begin
            s_next.words = WB_DAT_I[CTRL_WORDS_LO +: 4];
         end
         s_next.rst_out = WB_DAT_I[CTRL_RST_OUT];
         s_next.iface_rst = WB_DAT_I[CTRL_IFACE_RST];
         s_next.sys_rst = WB_DAT_I[CTRL_SYS_RST];
      end
      // write one to clear, a new event in the same cycle wins; a transfer ending in that cycle keeps an old preempt flag
      if (wr_stat && WB_DAT_I[STAT_DONE]) begin
         s_next.done = 1'b0;
      end
      if (wr_stat && WB_DAT_I[STAT_PREEMPT]) begin
         s_next.preempt = 1'b0;
      end
      if (wr_stat && WB_DAT_I[STAT_UNALIGNED]) begin
         s_next.unaligned = 1'b0;
      end

      if (!s_reg.aligned) begin
         if (!pin_s.align_skip_n || (s_reg.align_cnt == ALIGN_LAST)) begin // RULE15
            s_next.aligned = 1'b1;
         end else begin
            s_next.align_cnt = s_reg.align_cnt + 5'h01;
         end
      end

      s_next.dpu.strobe_n = 1'b1;
      s_next.dpu.step_n = 1'b1;
      case (s_reg.fsm)
         ST_IDLE: begin
            if (go && s_reg.aligned && (WB_DAT_I[CTRL_CODE_LO +: 3] != ACT_RESERVED)) begin // RULE5
               s_next.fsm = ST_REQ;
               s_next.rq = WB_DAT_I[CTRL_DMA] ? RQ_DMA : RQ_OTHER; // RULE17
            end
         end
         ST_REQ: begin
            if (pin_s.awarded && !pin_s.tenure_end) begin // RULE16
               s_next.fsm = ST_LOAD;
               s_next.rq = RQ_NONE;
               s_next.dpu.addr_load_n = 1'b0; // RULE3
               s_next.dpu.owner_n = 1'b0; // RULE4
               s_next.dpu.action = s_reg.code; // RULE5
               s_next.dir = 1'b0; // RULE18
            end
         end
         ST_LOAD: begin
            s_next.fsm = ST_STROBE;
            s_next.dpu.addr_load_n = 1'b1;
            s_next.dpu.strobe_n = 1'b0; // RULE6
         end
         ST_STROBE: begin
            s_next.fsm = ST_STEP;
            s_next.dpu.step_n = 1'b0; // RULE7
         end
         ST_STEP: begin
            s_next.fsm = ST_XFER;
         end
         ST_XFER: begin
            if (pin_s.takeover || (s_reg.words == 4'h0)) begin // RULE19
               s_next.fsm = ST_END;
               s_next.preempt = s_reg.preempt || (pin_s.takeover && (s_reg.words != 4'h0));
            end else begin
               s_next.words = s_reg.words - 4'h1;
               s_next.fsm = ST_STEP;
               s_next.dpu.step_n = 1'b0; // RULE7
            end
         end
         ST_END: begin
            s_next.fsm = ST_IDLE;
            s_next.dpu.owner_n = 1'b1;
            s_next.dpu.action = ACT_RESERVED;
            s_next.dir = 1'b1; // RULE18
            s_next.done = 1'b1;
         end
         default: begin
            s_next.fsm = ST_IDLE;
         end
      endcase

      s_next.last_decode = pin_s.addr_decode;
      s_next.dpu.selected_n = !(s_next.dpu.owner_n && slave_hit(pin_s.addr_decode)); // RULE1 RULE8
      s_next.slave_hit = s_reg.slave_hit || (s_reg.dpu.owner_n && slave_hit(pin_s.addr_decode)); // RULE1
      if (wr_stat && WB_DAT_I[STAT_SLAVE_HIT]) begin
         s_next.slave_hit = s_reg.dpu.owner_n && slave_hit(pin_s.addr_decode);
      end
      if (!s_reg.dpu.selected_n && !pin_s.unaligned_n) begin // RULE9
         s_next.unaligned = 1'b1;
      end
      s_next.idle_n = !(bus_idle && s_reg.rst_out); // RULE11

      if (!pin_s.pwr_rst_n) begin // RULE14
         s_next = ST_RESET;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         s_reg <= ST_RESET;
      end else if (CE) begin
         s_reg <= s_next;
      end
   end

   assign WB_DAT_O = s_reg.rdata;
   assign WB_ACK_O = s_reg.ack;
   assign GRANT_ADDR_LOAD_N = s_reg.dpu.addr_load_n;
   assign HOST_SIDE_OWNER_N = s_reg.dpu.owner_n;
   assign HOST_ACTION_CODE = s_reg.dpu.action;
   assign HOST_ACTION_STROBE_N = s_reg.dpu.strobe_n;
   assign ADDR_STEP_N = s_reg.dpu.step_n;
   assign MODULE_SELECTED_N = s_reg.dpu.selected_n;
   assign TENURE_REQUEST_LEVEL = s_reg.rq;
   assign CMD_XCVR_DIR = s_reg.dir;
   assign BACKPLANE_RESET_OUT = s_reg.rst_out;
   assign IDLE_BUS_FLAG_N = s_reg.idle_n;
   // open collector: drive low only while requested, otherwise released
   assign IFACE_RESET_REQUEST_N_O = 1'b0;
   assign IFACE_RESET_REQUEST_N_OE = s_reg.iface_rst; // RULE12
   assign WHOLE_SYSTEM_RESET_REQUEST_N_O = 1'b0;
   assign WHOLE_SYSTEM_RESET_REQUEST_N_OE = s_reg.sys_rst; // RULE13

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET || !CE);

   sequence granted_s;
      (s_reg.fsm == ST_REQ) && pin_s.awarded && !pin_s.tenure_end && pin_s.pwr_rst_n;
   endsequence
   sequence load_strobe_s;
      !GRANT_ADDR_LOAD_N && !HOST_SIDE_OWNER_N ##1 !HOST_ACTION_STROBE_N && GRANT_ADDR_LOAD_N;
   endsequence

   chk_grant_load_seq: assert property (granted_s |=> load_strobe_s) // RULE3
      else $error("load and strobe did not follow grant");
   chk_tenure_wait: assert property (((s_reg.fsm == ST_REQ) && pin_s.tenure_end) |=> GRANT_ADDR_LOAD_N) // RULE16
      else $error("tenure began while end of tenure held");
   chk_owner_busy: assert property (!HOST_SIDE_OWNER_N |-> // RULE4
      (s_reg.fsm inside {ST_LOAD, ST_STROBE, ST_STEP, ST_XFER, ST_END}))
      else $error("host owner low outside a mastered transfer");
   chk_code_valid: assert property (!HOST_ACTION_STROBE_N |-> // RULE5
      (HOST_ACTION_CODE != 3'h0) && !HOST_SIDE_OWNER_N)
      else $error("strobe with reserved action code");
   chk_strobe_pulse: assert property ($fell(HOST_ACTION_STROBE_N) |=> HOST_ACTION_STROBE_N[*3]) // RULE6
      else $error("action strobe not a single pulse");
   chk_step_pulse: assert property (!ADDR_STEP_N |=> ADDR_STEP_N) else $error("step pulse too long"); // RULE7
   chk_select_owner: assert property (!MODULE_SELECTED_N |-> HOST_SIDE_OWNER_N) // RULE8
      else $error("selected while mastering");
   chk_idle_flag: assert property (!IDLE_BUS_FLAG_N |-> $past(BACKPLANE_RESET_OUT) && $past(bus_idle)) // RULE11
      else $error("bus idle flag without cause");
   chk_req_level: assert property ((s_reg.fsm == ST_REQ) |-> // RULE17
      (TENURE_REQUEST_LEVEL == (s_reg.dma ? 2'h1 : 2'h2)))
      else $error("wrong request level");
   chk_dir_write: assert property (!HOST_SIDE_OWNER_N |-> !CMD_XCVR_DIR) // RULE18
      else $error("command direction not write while master");
   chk_preempt_end: assert property (((s_reg.fsm == ST_XFER) && pin_s.takeover && pin_s.pwr_rst_n) |=> // RULE19
      (s_reg.fsm == ST_END) ##1 HOST_SIDE_OWNER_N) else $error("preemption not honoured");
   chk_pwr_reset: assert property (!pin_s.pwr_rst_n |=> HOST_SIDE_OWNER_N && !IFACE_RESET_REQUEST_N_OE // RULE14
      && !WHOLE_SYSTEM_RESET_REQUEST_N_OE && (TENURE_REQUEST_LEVEL == 2'h0))
      else $error("outputs not released by power up reset");
endmodule : dp_reset_ctl
`default_nettype wire

// ---- sim/far_side_model.sv ----
// far side model: decode pins, arbitration pins and backplane arbiter
`default_nettype none
module far_side_model import bridge_ctl_pkg::*; (
   input wire logic CLK,
   input wire logic [1:0] rq_level,
   input wire logic owner_n,
   input wire logic step_n,
   input wire logic selected_n,
   input wire logic [3:0] decode_cfg,
   input wire logic partial,
   input wire logic quiet,
   input wire logic slow,
   input wire logic preempt_en,
   output logic [3:0] decode,
   output logic unaligned_n,
   output logic arb_a,
   output logic arb_b,
   output logic awarded,
   output logic tenure_end,
   output logic takeover
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_cnt = 4'h0;
   logic toggle = 1'h0;
   logic take_reg = 1'h0;
   assign decode = decode_cfg;
   assign unaligned_n = !(partial && !selected_n);
   // a busy arbitration bus never shows the quiet pair
   assign arb_a = quiet ? 1'h0 : toggle;
   assign arb_b = quiet ? 1'h1 : toggle;
   // grant arrives while the previous tenure is still ending
   assign awarded = wait_cnt >= 4'h3;
   assign tenure_end = awarded && wait_cnt < (slow ? 4'hE : 4'h5);
   assign takeover = take_reg;
   always @(posedge CLK) begin
      toggle <= !toggle;
      if (rq_level == RQ_NONE && owner_n) begin
         wait_cnt <= 4'h0;
         take_reg <= 1'h0;
      end else begin
         if (wait_cnt != 4'hF) begin
            wait_cnt <= wait_cnt + 4'h1;
         end
         if (preempt_en && !step_n) begin
            take_reg <= 1'h1;
         end
      end
   end
endmodule : far_side_model
`default_nettype wire

// ---- sim/tb_dp_reset_ctl.sv ----
// self-checking testbench for the data path and reset controller
`default_nettype none
module tb_dp_reset_ctl import bridge_ctl_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 1'h0;
   logic RESET = 1'h1;
   logic cyc = 1'h0;
   logic stb = 1'h0;
   logic we = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic pwr_n = 1'h1;
   logic skip_n = 1'h1;
   logic [3:0] dec_cfg = 4'h0;
   logic partial = 1'h0;
   logic quiet = 1'h0;
   logic slow = 1'h0;
   logic pre_en = 1'h0;
   logic ce = 1'h1;
   logic [31:0] rdat, rdv;
   logic ack, load_n, owner_n, strobe_n, step_n, sel_n, dir, rst_out, idle_n;
   logic if_o, if_oe, sys_o, sys_oe, unal_n, arb_a, arb_b, aw, te, tk;
   logic [2:0] act;
   logic [2:0] code_exp = 3'h0;
   logic [1:0] rq;
   logic [1:0] lvl = 2'h0;
   logic [3:0] dec;
   int err_total = 0;
   int checks_done = 0;
   int ticks = 0;
   int n_load, n_strobe, n_step, n_own, n_early, n_bad;
   // open-drain request pins with a pull-up
   wire logic if_pin = if_oe ? if_o : 1'h1;
   wire logic sys_pin = sys_oe ? sys_o : 1'h1;

   always #(CLK_PERIOD_NS / 2) CLK = !CLK;

   dp_reset_ctl DUT (.CLK(CLK), .RESET(RESET), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .HOST_ADDR_DECODE(dec), .UNALIGNED_N(unal_n), .ARB_QUIET_HS_A(arb_a), .ARB_QUIET_HS_B(arb_b),
      .TENURE_END_IN(te), .MASTERSHIP_AWARDED_IN(aw), .TAKEOVER_IN(tk), .PWR_RESET_N(pwr_n),
      .ALIGN_SKIP_N(skip_n), .GRANT_ADDR_LOAD_N(load_n), .HOST_SIDE_OWNER_N(owner_n), .HOST_ACTION_CODE(act),
      .HOST_ACTION_STROBE_N(strobe_n), .ADDR_STEP_N(step_n), .MODULE_SELECTED_N(sel_n),
      .TENURE_REQUEST_LEVEL(rq), .CMD_XCVR_DIR(dir), .BACKPLANE_RESET_OUT(rst_out), .IDLE_BUS_FLAG_N(idle_n),
      .IFACE_RESET_REQUEST_N_O(if_o), .IFACE_RESET_REQUEST_N_OE(if_oe),
      .WHOLE_SYSTEM_RESET_REQUEST_N_O(sys_o), .WHOLE_SYSTEM_RESET_REQUEST_N_OE(sys_oe));

   far_side_model far (.CLK(CLK), .rq_level(rq), .owner_n(owner_n), .step_n(step_n), .selected_n(sel_n),
      .decode_cfg(dec_cfg), .partial(partial), .quiet(quiet), .slow(slow), .preempt_en(pre_en),
      .decode(dec), .unaligned_n(unal_n), .arb_a(arb_a), .arb_b(arb_b), .awarded(aw), .tenure_end(te),
      .takeover(tk));

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   // pulse counters and per-cycle watch of the unit's control pins
   always @(posedge CLK) begin
      ticks++;
      n_load += !load_n;
      n_strobe += !strobe_n;
      n_step += !step_n;
      n_own += !owner_n;
      n_early += !load_n && te;
      n_bad += !owner_n && (act !== code_exp || dir !== 1'h0);
      if (rq !== RQ_NONE) lvl = rq;
      if (ticks == 30000) begin
         err_total++;
         stop_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s, seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge CLK);
      while (ack !== 1'h1);
      rdv = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask : wb

   task automatic xfer(input logic dma, input logic [2:0] code, input logic [3:0] wm1, input logic pre);
      code_exp = code;
      lvl = RQ_NONE;
      n_load = 0;
      n_strobe = 0;
      n_step = 0;
      n_own = 0;
      n_early = 0;
      n_bad = 0;
      pre_en <= pre;
      wb(1'h1, OFS_CTRL, {20'h0, wm1, 3'h0, code, dma, 1'h1});
      do wb(1'h0, OFS_STATUS, 32'h0);
      while (rdv[STAT_DONE] !== 1'h1);
      check(n_load, 1, "address load pulses");
      check(n_strobe, 1, "action strobe pulses");
      check(n_early, 0, "load before tenure end released");
      check(lvl, dma ? RQ_DMA : RQ_OTHER, "request level");
      check(n_bad, 0, "action code or direction while owner");
      check(n_own > 0, 1, "owner asserted");
      if (pre) begin
         check(n_step < wm1 + 1, 1, "steps after takeover");
         check(rdv[STAT_PREEMPT], 1, "takeover flag");
      end else
         check(n_step, wm1 + 1, "address steps");
      check({owner_n, dir, act}, 5'h18, "released after transfer");
      wb(1'h1, OFS_STATUS, 32'h4B);
   endtask : xfer

   task automatic pwr(input logic s);
      skip_n <= s;
      pwr_n <= 1'h0;
      @(posedge CLK);
      pwr_n <= 1'h1;
      repeat (6) @(posedge CLK);
   endtask : pwr

   initial begin
      logic hit;
      int n;
      repeat (4) @(posedge CLK);
      RESET <= 1'h0;
      do wb(1'h0, OFS_STATUS, 32'h0);
      while (rdv[STAT_ALIGNED] !== 1'h1);
      wb(1'h1, 8'h40, 32'hFFFF_FFFF);
      wb(1'h0, 8'h40, 32'h0);
      check(rdv, 32'h0, "unmapped read");
      lvl = RQ_NONE;
      wb(1'h1, OFS_CTRL, 32'h301);
      wb(1'h0, OFS_STATUS, 32'h0);
      check({lvl, rdv[STAT_BUSY]}, 3'h0, "reserved action code start");
      for (int c = 1; c < 8; c++) begin
         slow <= c[1];
         xfer(c[0], 3'(c), 4'(c == 7 ? 15 : c - 1), 1'h0);
      end
      xfer(1'h1, 3'h2, 4'hF, 1'h1);
      for (int c = 0; c < 16; c++) begin
         dec_cfg <= 4'(c);
         repeat (4) @(posedge CLK);
         hit = c inside {1, 2, 3, 4, 6, 7, 9, 13};
         check(sel_n, !hit, "module selected");
         wb(1'h0, OFS_DECODE, 32'h0);
         check(rdv[4:0], {c >= 1 && c <= 6, 4'(c)}, "decode register");
      end
      wb(1'h1, OFS_STATUS, 32'h4B);
      dec_cfg <= 4'h1;
      partial <= 1'h1;
      repeat (6) @(posedge CLK);
      partial <= 1'h0;
      dec_cfg <= 4'h0;
      wb(1'h0, OFS_STATUS, 32'h0);
      check({rdv[STAT_SLAVE_HIT], rdv[STAT_UNALIGNED]}, 2'h3, "slave hit and unaligned");
      wb(1'h1, OFS_STATUS, 32'h4B);
      quiet <= 1'h1;
      repeat (IDLE_CYCLES + 10) @(posedge CLK);
      wb(1'h0, OFS_STATUS, 32'h0);
      check({rdv[STAT_IDLE], idle_n}, 2'h3, "quiet bus without reset out");
      wb(1'h1, OFS_CTRL, 32'h1000);
      repeat (3) @(posedge CLK);
      check({rst_out, idle_n}, 2'h2, "quiet bus with reset out");
      quiet <= 1'h0;
      repeat (6) @(posedge CLK);
      check(idle_n, 1'h1, "busy arbitration bus");
      n = 0;
      quiet <= 1'h1;
      do begin
         @(posedge CLK);
         n++;
      end while (idle_n !== 1'h0 && n < 200);
      check(n > IDLE_CYCLES && n < IDLE_CYCLES + 10, 1, "idle delay");
      wb(1'h1, OFS_CTRL, 32'h3000);
      repeat (2) @(posedge CLK);
      check({if_pin, sys_pin, sys_oe}, 3'h2, "interface reset request");
      wb(1'h1, OFS_CTRL, 32'h5000);
      repeat (2) @(posedge CLK);
      check({if_pin, sys_pin, if_oe}, 3'h4, "system reset request");
      pwr(1'h1);
      check({load_n, owner_n, strobe_n, step_n, sel_n, dir, idle_n, act, rq, rst_out, if_oe, sys_oe, ack},
         16'hFE00, "outputs in power-up reset");
      wb(1'h0, OFS_STATUS, 32'h0);
      check(rdv[STAT_ALIGNED], 1'h0, "alignment running");
      ce <= 1'h0;
      repeat (20) @(posedge CLK);
      ce <= 1'h1;
      wb(1'h0, OFS_STATUS, 32'h0);
      check(rdv[STAT_ALIGNED], 1'h0, "alignment frozen while disabled");
      pwr(1'h0);
      wb(1'h0, OFS_STATUS, 32'h0);
      check(rdv[STAT_ALIGNED], 1'h1, "alignment skipped");
      stop_test();
   end
endmodule : tb_dp_reset_ctl
`default_nettype wire
